// File: bbc_pkg.sv
// Constants, opcode columns and phase type for the branch, bit and control decoder.
// Assumes an 8-bit opcode stream and a 12-bit program counter.
package bbc_pkg;
	localparam int PC_W   = 12;
	localparam int DATA_W = 8;

	localparam logic [11:0] RESET_PC = 12'h000;

	// Low-nibble opcode columns
	localparam logic [3:0] COL_BR_NZ      = 4'h0;
	localparam logic [3:0] COL_CALL       = 4'h1;
	localparam logic [3:0] COL_BR_NC      = 4'h2;
	localparam logic [3:0] COL_BIT_TEST   = 4'h3;
	localparam logic [3:0] COL_BR_Z       = 4'h4;
	localparam logic [3:0] COL_BR_C       = 4'h6;
	localparam logic [3:0] COL_JUMP       = 4'h9;
	localparam logic [3:0] COL_BIT_DIRECT = 4'hB;

	// Inherent control opcodes
	localparam logic [7:0] OP_NOP      = 8'h04;
	localparam logic [7:0] OP_SUB_EXIT = 8'hCD;
	localparam logic [7:0] OP_INT_EXIT = 8'h4D;
	localparam logic [7:0] OP_STOP     = 8'h6D;
	localparam logic [7:0] OP_WAIT     = 8'hED;

	// Opcode field positions
	localparam int BIT_IDX_LSB = 5;
	localparam int SEL_BIT     = 4;
	localparam int DISP_LSB    = 3;

	// Cycle counts per instruction
	localparam logic [2:0] CYC_SHORT      = 3'h2;
	localparam logic [2:0] CYC_CTRL       = 3'h2;
	localparam logic [2:0] CYC_EXT        = 3'h4;
	localparam logic [2:0] CYC_BIT_DIRECT = 3'h4;
	localparam logic [2:0] CYC_BIT_TEST   = 3'h5;

	// Byte lengths used for the fall-through address
	localparam logic [11:0] LEN_ONE   = 12'h001;
	localparam logic [11:0] LEN_TWO   = 12'h002;
	localparam logic [11:0] LEN_THREE = 12'h003;

	typedef enum logic [2:0] {
		ST_FETCH  = 3'b000,
		ST_OPCODE = 3'b001,
		ST_OPER1  = 3'b010,
		ST_OPER2  = 3'b011,
		ST_EXEC   = 3'b100
	} phase_t;
endpackage

// File: ret_stack_if.sv
// Push and pop signals between the decoder and its return address stack.
// Assumes one push or one pop per clock at most.
`timescale 1ns/100ps
interface ret_stack_if;
	logic        push;
	logic        pop;
	logic [11:0] push_addr;
	logic [11:0] top;
	modport owner (output push, output pop, output push_addr, input top);
	modport store (input push, input pop, input push_addr, output top);
endinterface

// File: return_stack.sv
// Small circular return address stack.
// Assumes the decoder never pushes and pops in the same cycle.
`timescale 1ns/100ps
module return_stack #(
	parameter int DEPTH = 4
) (
	input  wire logic   clk,
	input  wire logic   rst_b,
	ret_stack_if.store  rs
);
	import bbc_pkg::*;

	localparam int PTR_W = $clog2(DEPTH);

	logic [11:0]      slot [DEPTH];
	logic [PTR_W-1:0] ptr;

	// Overflow silently overwrites the oldest entry, as a plain hardware stack does
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ptr <= '0;
		else if (rs.push)
			ptr <= ptr + 1'b1;
		else if (rs.pop)
			ptr <= ptr - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (rs.push)
			slot[ptr] <= rs.push_addr;
	end

	assign rs.top = slot[ptr - 1'b1];
endmodule

// File: branch_bit_control_decoder.sv
// Decoder and sequencer for relative branches, bit test and branch, bit set and clear,
// long jump, call and the inherent control instructions.
// Assumes program memory answers one cycle after pm_addr, and data memory reads
// combinationally from dm_addr and writes on dm_we.
`timescale 1ns/100ps
module branch_bit_control_decoder #(
	parameter int STACK_DEPTH = 4
) (
	input  wire logic               clk,
	input  wire logic               rst_b,
	output logic [bbc_pkg::PC_W-1:0]   pm_addr,
	input  wire logic [bbc_pkg::DATA_W-1:0] pm_rdata,
	output logic [bbc_pkg::DATA_W-1:0] dm_addr,
	output logic [bbc_pkg::DATA_W-1:0] dm_wdata,
	output logic                    dm_we,
	input  wire logic [bbc_pkg::DATA_W-1:0] dm_rdata,
	input  wire logic               watchdog_sel,
	input  wire logic               int_saved_z,
	input  wire logic               int_saved_c,
	output logic                    flag_z,
	output logic                    flag_c,
	output logic                    stop_req,
	output logic                    wait_req,
	output logic                    instr_done
);
	import bbc_pkg::*;

	phase_t      phase;
	logic [11:0] pc;
	logic [7:0]  op;
	logic [7:0]  oper1;
	logic        test_bit;
	logic [7:0]  cur_op;
	logic [2:0]  n_cyc;
	logic        last;
	logic [11:0] next_pc;
	logic        is_short;
	logic        short_taken;
	logic [2:0]  bit_idx;

	ret_stack_if rs ();

	return_stack #(
		.DEPTH (STACK_DEPTH)
	) u_stack (
		.clk   (clk),
		.rst_b (rst_b),
		.rs    (rs.store)
	);

	function automatic logic [2:0] cycles_of(input logic [7:0] o);
		if (o[3:0] == COL_BIT_TEST)
			return CYC_BIT_TEST;
		else if (o[3:0] == COL_BIT_DIRECT)
			return CYC_BIT_DIRECT;
		else if (o[3:0] == COL_CALL || o[3:0] == COL_JUMP)
			return CYC_EXT;
		else if (o[3:0] == OP_WAIT[3:0])
			return CYC_CTRL;
		else
			return CYC_SHORT;
	endfunction

	// Column decode
	// Bit 3 is the low displacement bit, so columns 8 to E repeat the lower four
	function automatic logic short_col(input logic [7:0] o);
		return o[2:0] == COL_BR_NZ[2:0] || o[2:0] == COL_BR_NC[2:0]
			|| o[2:0] == COL_BR_Z[2:0] || o[2:0] == COL_BR_C[2:0];
	endfunction

	assign cur_op  = (phase == ST_OPCODE) ? pm_rdata : op;
	assign n_cyc   = cycles_of(cur_op);
	assign last    = (phase == phase_t'(n_cyc - 3'h1));
	assign bit_idx = op[BIT_IDX_LSB +: 3];

	always_comb
	begin
		is_short = short_col(cur_op);
		case (cur_op[2:0])
			COL_BR_NZ[2:0]: short_taken = !flag_z;
			COL_BR_NC[2:0]: short_taken = !flag_c;
			COL_BR_Z[2:0]:  short_taken = flag_z;
			default:        short_taken = flag_c;
		endcase
	end

	// Opcode 04 is a zero-span zero branch, which lands on the next byte anyway
	always_comb
	begin
		next_pc      = pc + LEN_ONE;
		rs.push      = 1'b0;
		rs.pop       = 1'b0;
		rs.push_addr = pc + LEN_TWO;
		if (is_short)
		begin
			if (short_taken)
				next_pc = pc + LEN_ONE + {{7{cur_op[7]}}, cur_op[DISP_LSB +: 5]};
		end
		else if (cur_op[3:0] == COL_CALL || cur_op[3:0] == COL_JUMP)
		begin
			next_pc = {cur_op[7:4], oper1};
			rs.push = last && (cur_op[3:0] == COL_CALL);
		end
		else if (cur_op[3:0] == COL_BIT_TEST)
		begin
			if (test_bit == cur_op[SEL_BIT])
				next_pc = pc + LEN_TWO + {{4{oper1[7]}}, oper1};
			else
				next_pc = pc + LEN_THREE;
		end
		else if (cur_op[3:0] == COL_BIT_DIRECT)
			next_pc = pc + LEN_TWO;
		else if (cur_op == OP_SUB_EXIT || cur_op == OP_INT_EXIT)
		begin
			next_pc = rs.top;
			rs.pop  = last;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			phase <= ST_FETCH;
		else if (last)
			phase <= ST_FETCH;
		else
			phase <= phase_t'(phase + 3'h1);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pc      <= RESET_PC;
			pm_addr <= RESET_PC;
		end
		else if (last)
		begin
			pc      <= next_pc;
			pm_addr <= next_pc;
		end
		else if (phase == ST_FETCH || phase == ST_OPCODE)
			pm_addr <= pm_addr + LEN_ONE;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			op    <= 8'h00;
			oper1 <= 8'h00;
		end
		else if (phase == ST_OPCODE)
			op <= pm_rdata;
		else if (phase == ST_OPER1 || (phase == ST_OPER2 && op[3:0] == COL_BIT_TEST))
			oper1 <= pm_rdata;
	end

	// Data access for bit test and bit direct
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dm_addr  <= 8'h00;
			dm_wdata <= 8'h00;
			dm_we    <= 1'b0;
			test_bit <= 1'b0;
		end
		else
		begin
			dm_we <= 1'b0;
			if (phase == ST_OPER1 && (op[3:0] == COL_BIT_TEST || op[3:0] == COL_BIT_DIRECT))
				dm_addr <= pm_rdata;
			if (phase == ST_OPER2 && op[3:0] == COL_BIT_TEST)
				test_bit <= dm_rdata[bit_idx];
			if (phase == ST_OPER2 && op[3:0] == COL_BIT_DIRECT)
			begin
				dm_wdata          <= dm_rdata;
				dm_wdata[bit_idx] <= op[SEL_BIT];
				dm_we             <= 1'b1;
			end
		end
	end

	// Only bit test and interrupt exit touch the flags
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			flag_z <= 1'b0;
			flag_c <= 1'b0;
		end
		else if (phase == ST_OPER2 && op[3:0] == COL_BIT_TEST)
			flag_c <= dm_rdata[bit_idx];
		else if (last && cur_op == OP_INT_EXIT)
		begin
			flag_z <= int_saved_z;
			flag_c <= int_saved_c;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stop_req   <= 1'b0;
			wait_req   <= 1'b0;
			instr_done <= 1'b0;
		end
		else
		begin
			instr_done <= last;
			stop_req   <= last && cur_op == OP_STOP && !watchdog_sel;
			wait_req   <= last && (cur_op == OP_WAIT || (cur_op == OP_STOP && watchdog_sel));
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_short_two;
		(phase == ST_OPCODE && short_col(pm_rdata)) |=> (phase == ST_FETCH && instr_done
			&& flag_z == $past(flag_z) && flag_c == $past(flag_c));
	endproperty
	a_short_two: assert property (p_short_two) else $error("short branch timing or flags");

	property p_short_span;
		(phase == ST_OPCODE && short_col(pm_rdata)) |=>
			($signed(pc - $past(pc)) >= -15 && $signed(pc - $past(pc)) <= 16);
	endproperty
	a_short_span: assert property (p_short_span) else $error("short branch out of span");

	property p_test_five;
		(phase == ST_OPCODE && pm_rdata[3:0] == COL_BIT_TEST) |=> !instr_done [*3] ##1 instr_done;
	endproperty
	a_test_five: assert property (p_test_five) else $error("bit test not five cycles");

	property p_test_carry;
		(phase == ST_OPER2 && op[3:0] == COL_BIT_TEST) |=>
			(flag_c == $past(dm_rdata[bit_idx]) && $stable(flag_z));
	endproperty
	a_test_carry: assert property (p_test_carry) else $error("tested bit not in carry");

	property p_test_span;
		(phase == ST_EXEC) |=> ($signed(pc - $past(pc)) >= -126 && $signed(pc - $past(pc)) <= 129);
	endproperty
	a_test_span: assert property (p_test_span) else $error("bit test branch out of span");

	property p_bit_write;
		(phase == ST_OPER2 && op[3:0] == COL_BIT_DIRECT) |=>
			(dm_we && dm_wdata[$past(bit_idx)] == $past(op[SEL_BIT]) && instr_done && $stable(flag_c));
	endproperty
	a_bit_write: assert property (p_bit_write) else $error("bit direct write wrong");

	property p_ctrl_two;
		(phase == ST_OPCODE && (pm_rdata == OP_WAIT || pm_rdata == OP_SUB_EXIT))
			|=> (phase == ST_FETCH && $stable(flag_z) && $stable(flag_c));
	endproperty
	a_ctrl_two: assert property (p_ctrl_two) else $error("control instruction wrong");

	property p_stop_wd;
		(phase == ST_OPCODE && pm_rdata == OP_STOP && watchdog_sel) |=> (wait_req && !stop_req);
	endproperty
	a_stop_wd: assert property (p_stop_wd) else $error("stop not replaced by wait");

	property p_ext_target;
		(phase == ST_OPCODE && pm_rdata[3:0] == COL_JUMP) |=> ##2 (instr_done && pc[11:8] == op[7:4]
			&& pc[7:0] == oper1 && $stable(flag_z));
	endproperty
	a_ext_target: assert property (p_ext_target) else $error("long jump target wrong");

	property p_call_return;
		(phase == ST_OPCODE && (pm_rdata == OP_SUB_EXIT || pm_rdata == OP_INT_EXIT))
			|=> pc == $past(rs.top);
	endproperty
	a_call_return: assert property (p_call_return) else $error("exit did not resume");
endmodule

// File: bbc_mem_model.sv
// Program and data memory seen by the decoder.
// Assumes the bench preloads prog and dmem before releasing reset.
`timescale 1ns/100ps
module bbc_mem_model (
	input  wire logic                       clk,
	input  wire logic [bbc_pkg::PC_W-1:0]   pm_addr,
	output logic      [bbc_pkg::DATA_W-1:0] pm_rdata,
	input  wire logic [bbc_pkg::DATA_W-1:0] dm_addr,
	input  wire logic [bbc_pkg::DATA_W-1:0] dm_wdata,
	input  wire logic                       dm_we,
	output logic      [bbc_pkg::DATA_W-1:0] dm_rdata
);
	import bbc_pkg::*;
	logic [DATA_W-1:0] prog [0:4095];
	logic [DATA_W-1:0] dmem [0:255];

	// Fixed one-cycle latency, never stalls; plain RAM only, so bit ops stay safe
	always @(posedge clk)
	begin
		pm_rdata <= prog[pm_addr];
		if (dm_we)
			dmem[dm_addr] <= dm_wdata;
	end

	assign dm_rdata = dmem[dm_addr];
endmodule

// File: testbench.sv
// Self-checking bench for the branch, bit and control decoder.
// Assumes the memory model answers program reads one cycle late.
`timescale 1ns/100ps
module testbench;
	import bbc_pkg::*;
	logic              clk;
	logic              rst_b;
	logic [PC_W-1:0]   pm_addr;
	logic [DATA_W-1:0] pm_rdata;
	logic [DATA_W-1:0] dm_addr;
	logic [DATA_W-1:0] dm_wdata;
	logic              dm_we;
	logic [DATA_W-1:0] dm_rdata;
	logic              watchdog_sel;
	logic              int_saved_z;
	logic              int_saved_c;
	logic              flag_z;
	logic              flag_c;
	logic              stop_req;
	logic              wait_req;
	logic              instr_done;
	int                bad_count;
	int                compares;

	branch_bit_control_decoder branch_bit_control_decoder_i (
		.clk(clk), .rst_b(rst_b), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
		.dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata),
		.watchdog_sel(watchdog_sel), .int_saved_z(int_saved_z), .int_saved_c(int_saved_c),
		.flag_z(flag_z), .flag_c(flag_c), .stop_req(stop_req), .wait_req(wait_req),
		.instr_done(instr_done)
	);

	bbc_mem_model bbc_mem_model_i (
		.clk(clk), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_addr(dm_addr),
		.dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task test_done;
		$display("Checks made: %0d, mismatches: %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task put(input logic [PC_W-1:0] a, input logic [DATA_W-1:0] b);
		bbc_mem_model_i.prog[a] = b;
	endtask

	task restart;
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
	endtask

	// Waits for the completion pulse; cyc of 0 skips the cycle count
	task automatic step(input logic [PC_W-1:0] pc, input int cyc);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (instr_done !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			check(1'b0, "no completion pulse");
			test_done;
		end
		if (cyc != 0)
			check(n == cyc, "cycle count");
		check(pm_addr === pc, "next address");
	endtask

	task test_branches;
		put(12'h000, OP_NOP);
		put(12'h001, 8'h31);
		put(12'h002, 8'h20);
		put(12'h320, OP_INT_EXIT);
		put(12'h003, 8'h74);
		put(12'h012, 8'h80);
		put(12'h013, 8'h82);
		put(12'h004, 8'h76);
		put(12'h005, 8'h19);
		put(12'h006, 8'h40);
		put(12'h140, 8'h21);
		put(12'h141, 8'h50);
		put(12'h250, OP_SUB_EXIT);
		put(12'h142, 8'h7C);
		restart;
		step(12'h001, 0);
		step(12'h320, 4);
		step(12'h003, 2);
		check(flag_z === 1'b1 && flag_c === 1'b0, "flags after interrupt exit");
		step(12'h012, 2);
		step(12'h013, 2);
		step(12'h004, 2);
		step(12'h005, 2);
		step(12'h140, 4);
		step(12'h250, 4);
		step(12'h142, 2);
		check(flag_z === 1'b1 && flag_c === 1'b0, "flags held by branches");
		step(12'h152, 2);
		$display("test_branches finished");
	endtask

	task test_bits;
		// plain RAM byte, no port register
		bbc_mem_model_i.dmem[8'h33] = 8'h20;
		put(12'h000, OP_NOP);
		put(12'h001, 8'hB3);
		put(12'h002, 8'h33);
		put(12'h003, 8'h7F);
		put(12'h082, 8'hA3);
		put(12'h083, 8'h33);
		put(12'h084, 8'h80);
		put(12'h085, 8'h03);
		put(12'h086, 8'h33);
		put(12'h087, 8'h80);
		put(12'h007, 8'hFB);
		put(12'h008, 8'h33);
		put(12'h009, 8'hAB);
		put(12'h00A, 8'h33);
		put(12'h00B, OP_NOP);
		restart;
		step(12'h001, 0);
		step(12'h082, 5);
		check(flag_c === 1'b1 && flag_z === 1'b0, "carry from set bit");
		step(12'h085, 5);
		check(flag_c === 1'b1, "carry after untaken test");
		step(12'h007, 5);
		check(flag_c === 1'b0 && flag_z === 1'b0, "carry from clear bit");
		step(12'h009, 4);
		step(12'h00B, 4);
		step(12'h00C, 2);
		check(bbc_mem_model_i.dmem[8'h33] === 8'h80, "bit set and clear result");
		check(flag_c === 1'b0 && flag_z === 1'b0, "flags after bit ops");
		$display("test_bits finished");
	endtask

	task test_control;
		put(12'h000, OP_NOP);
		put(12'h001, OP_STOP);
		put(12'h002, OP_WAIT);
		restart;
		step(12'h001, 0);
		step(12'h002, 2);
		check(stop_req === 1'b1 && wait_req === 1'b0, "stop pulse");
		step(12'h003, 2);
		check(wait_req === 1'b1 && stop_req === 1'b0, "wait pulse");
		@(posedge clk);
		watchdog_sel <= 1'b1;
		restart;
		step(12'h001, 0);
		step(12'h002, 2);
		check(wait_req === 1'b1 && stop_req === 1'b0, "stop runs as wait");
		check(flag_z === 1'b0 && flag_c === 1'b0, "control flags held");
		$display("test_control finished");
	endtask

	initial
	begin
		rst_b = 1'b0;
		watchdog_sel = 1'b0;
		int_saved_z = 1'b1;
		int_saved_c = 1'b0;
		bad_count = 0;
		compares = 0;
		for (int i = 0; i < 4096; i++)
			bbc_mem_model_i.prog[i] = OP_NOP;
		for (int i = 0; i < 256; i++)
			bbc_mem_model_i.dmem[i] = 8'h00;
		test_branches;
		test_bits;
		test_control;
		test_done;
	end
endmodule
